/* File: core/edge_if.sv */
// strobe carrier from an edge finder to the ram core
`timescale 1ns/100ps
`default_nettype none

interface edge_if;
  logic strobe;
  modport source (output strobe);
  modport sink (input strobe);
endinterface

`default_nettype wire

/* File: core/embedded_ram_block.sv */
// configurable 4 kbit block ram with separate write and read ports
// How it works
// - the shape is 256x16 with mask, or 512x8, 1024x4, 2048x2 without one.
// - in the 16-bit shape a mask bit of 0 writes its data bit, 1 keeps it.
// - write data, mask and both addresses are registered before the array.
// - the write port acts on the rising write clock edge unless set to fall.
// - the read port acts on the rising read clock edge unless set to fall.
// - in the 16-bit shape the 8-bit write address picks one of 256 words.
// - in the 16-bit shape the 8-bit read address picks the word to present.
// - an optional image is preloaded into the array at configuration.
// - the preload never sets the word at address 0.
// - each port has its own enable and clock enable input.
`timescale 1ns/100ps
`default_nettype none

module embedded_ram_block #(
  parameter ram_pkg::ram_shape_type SHAPE = ram_pkg::ram_shape_wide16,
  parameter bit WR_FALLING = 1'b0,
  parameter bit RD_FALLING = 1'b0,
  parameter logic [ram_pkg::TOTAL_BITS-1:0] INIT_IMAGE =
    {ram_pkg::TOTAL_BITS{1'b0}}
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic wr_clk,
  input wire logic wr_en,
  input wire logic wr_clk_en,
  input wire logic [ram_pkg::MAX_ADDR_WIDTH-1:0] wr_addr,
  input wire logic [ram_pkg::MAX_DATA_WIDTH-1:0] wr_data,
  input wire logic [ram_pkg::MAX_DATA_WIDTH-1:0] wr_mask,
  input wire logic rd_clk,
  input wire logic rd_en,
  input wire logic rd_clk_en,
  input wire logic [ram_pkg::MAX_ADDR_WIDTH-1:0] rd_addr,
  output logic [ram_pkg::MAX_DATA_WIDTH-1:0] rd_data
);

  // ****************************************
  // shape
  // ****************************************
  localparam int W = ram_pkg::MAX_DATA_WIDTH >> SHAPE;
  localparam int AW = ram_pkg::BASE_ADDR_WIDTH + int'(SHAPE);
  localparam logic [ram_pkg::MAX_ADDR_WIDTH-1:0] ADDR_KEEP =
    ram_pkg::MAX_ADDR_WIDTH'((32'h1 << AW) - 1);
  localparam logic [ram_pkg::MAX_DATA_WIDTH-1:0] DATA_KEEP =
    ram_pkg::MAX_DATA_WIDTH'((32'h1 << W) - 1);
  localparam bit HAS_MASK = (SHAPE == ram_pkg::ram_shape_wide16);
  // address 0 is never preloaded
  localparam logic [ram_pkg::TOTAL_BITS-1:0] PRELOAD = INIT_IMAGE &
    ~{{(ram_pkg::TOTAL_BITS-ram_pkg::MAX_DATA_WIDTH){1'b0}}, DATA_KEEP};

  function automatic logic [11:0] bit_index(
    input logic [ram_pkg::MAX_ADDR_WIDTH-1:0] a, input int i);
    bit_index = 12'(int'(a) * W + i);
  endfunction

  function automatic logic [ram_pkg::MAX_DATA_WIDTH-1:0] word_at(
    input logic [ram_pkg::TOTAL_BITS-1:0] m,
    input logic [ram_pkg::MAX_ADDR_WIDTH-1:0] a);
    logic [ram_pkg::MAX_DATA_WIDTH-1:0] w;
    w = 16'h0000;
    for (int i = 0; i < W; i++) begin
      w[i] = m[bit_index(a, i)];
    end
    word_at = w;
  endfunction

  // ****************************************
  // port edges
  // ****************************************
  edge_if wr_edge ();
  edge_if rd_edge ();

  port_edge_finder #(.FALLING(WR_FALLING)) wr_finder (
    .clock(clock),
    .sys_rst(sys_rst),
    .level(wr_clk),
    .edge_out(wr_edge.source)
  );

  port_edge_finder #(.FALLING(RD_FALLING)) rd_finder (
    .clock(clock),
    .sys_rst(sys_rst),
    .level(rd_clk),
    .edge_out(rd_edge.source)
  );

  // ****************************************
  // input registers
  // ****************************************
  wire wr_take = wr_edge.strobe & wr_en & wr_clk_en;
  wire rd_take = rd_edge.strobe & rd_en & rd_clk_en;
  wire [ram_pkg::MAX_DATA_WIDTH-1:0] next_mask =
    HAS_MASK ? wr_mask : 16'h0000;

  logic wr_pending;
  logic rd_pending;
  logic [ram_pkg::MAX_ADDR_WIDTH-1:0] wr_addr_q;
  logic [ram_pkg::MAX_ADDR_WIDTH-1:0] rd_addr_q;
  logic [ram_pkg::MAX_DATA_WIDTH-1:0] wr_data_q;
  logic [ram_pkg::MAX_DATA_WIDTH-1:0] wr_mask_q;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      wr_pending <= 1'b0;
      rd_pending <= 1'b0;
    end else begin
      wr_pending <= wr_take;
      rd_pending <= rd_take;
    end
  end

  always_ff @(posedge clock) begin
    if (wr_take) begin
      wr_addr_q <= wr_addr & ADDR_KEEP;
      wr_data_q <= wr_data & DATA_KEEP;
      wr_mask_q <= next_mask;
    end
    if (rd_take) begin
      rd_addr_q <= rd_addr & ADDR_KEEP;
    end
  end

  // ****************************************
  // array
  // ****************************************
  logic [ram_pkg::TOTAL_BITS-1:0] mem = PRELOAD;

  always_ff @(posedge clock) begin
    if (wr_pending) begin
      for (int i = 0; i < W; i++) begin
        if (!wr_mask_q[i]) begin
          mem[bit_index(wr_addr_q, i)] <= wr_data_q[i];
        end
      end
    end
  end

  wire [ram_pkg::MAX_DATA_WIDTH-1:0] rd_word = word_at(mem, rd_addr_q);

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      rd_data <= ram_pkg::READ_DATA_RESET;
    end else if (rd_pending) begin
      rd_data <= rd_word;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  a_read_holds: assert property (@(posedge clock) disable iff (sys_rst)
    !rd_take |=> ##1 $stable(rd_data))
    else $error("read data changed without an enabled read edge");

  a_read_value: assert property (@(posedge clock) disable iff (sys_rst)
    rd_take |=> ##1 (rd_data == word_at($past(mem), rd_addr_q)))
    else $error("read data is not the addressed word");

  a_read_enables: assert property (@(posedge clock) disable iff (sys_rst)
    $rose(rd_pending) |-> $past(rd_en && rd_clk_en && rd_edge.strobe))
    else $error("read taken without both read enables");

  a_write_enables: assert property (@(posedge clock) disable iff (sys_rst)
    wr_pending |-> $past(wr_en && wr_clk_en && wr_edge.strobe))
    else $error("write taken without both write enables");

  a_idle_array: assert property (@(posedge clock) disable iff (sys_rst)
    !wr_pending |=> $stable(mem))
    else $error("array changed without a write");

  a_write_stores: assert property (@(posedge clock) disable iff (sys_rst)
    wr_take |=> ##1 ((word_at(mem, $past(wr_addr & ADDR_KEEP, 2)) &
      ~$past(next_mask, 2)) == ($past(wr_data & DATA_KEEP, 2) &
      ~$past(next_mask, 2))))
    else $error("unmasked write bits not stored");

  a_mask_keeps: assert property (@(posedge clock) disable iff (sys_rst)
    wr_pending |=> ((word_at(mem, $past(wr_addr_q)) & $past(wr_mask_q)) ==
      (word_at($past(mem), $past(wr_addr_q)) & $past(wr_mask_q))))
    else $error("masked bit was overwritten");

  a_addr_captured: assert property (@(posedge clock) disable iff (sys_rst)
    wr_take |=> (wr_addr_q == ($past(wr_addr) & ADDR_KEEP)) &&
      (wr_data_q == ($past(wr_data) & DATA_KEEP)))
    else $error("write inputs not registered on the active edge");

  a_read_captured: assert property (@(posedge clock) disable iff (sys_rst)
    rd_take |=> (rd_addr_q == ($past(rd_addr) & ADDR_KEEP)))
    else $error("read address not registered on the active edge");

  a_upper_zero: assert property (@(posedge clock) disable iff (sys_rst)
    (rd_data & ~DATA_KEEP) == 16'h0000)
    else $error("read data bits above the word width are set");

  a_mask_unused: assert property (@(posedge clock) disable iff (sys_rst)
    (wr_pending && !HAS_MASK) |-> (wr_mask_q == 16'h0000))
    else $error("mask applied in a shape without a mask");

  a_write_spacing: assert property (@(posedge clock) disable iff (sys_rst)
    wr_pending |=> !wr_pending)
    else $error("two writes from one write pin edge");

  a_read_spacing: assert property (@(posedge clock) disable iff (sys_rst)
    rd_pending |=> !rd_pending)
    else $error("two reads from one read pin edge");

  a_write_refused: assert property (@(posedge clock) disable iff (sys_rst)
    !wr_take |=> !wr_pending)
    else $error("write pending without a taken write edge");

  a_read_refused: assert property (@(posedge clock) disable iff (sys_rst)
    !rd_take |=> !rd_pending)
    else $error("read pending without a taken read edge");

endmodule

`default_nettype wire

/* File: core/port_edge_finder.sv */
// finds the selected edge of a port clock pin, sampled on the system clock
`timescale 1ns/100ps
`default_nettype none

module port_edge_finder #(
  parameter bit FALLING = 1'b0
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic level,
  edge_if.source edge_out
);

  logic prev;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      prev <= ram_pkg::EDGE_SAMPLE_RESET;
    end else begin
      prev <= level;
    end
  end

  // rising by default, falling when selected
  assign edge_out.strobe = FALLING ? (prev & ~level) : (~prev & level);

  // ****************************************
  // checks
  // ****************************************
  a_edge_polarity: assert property (@(posedge clock) disable iff (sys_rst)
    edge_out.strobe |-> (level == !FALLING) ##1 (prev == !FALLING))
    else $error("edge strobe does not match selected polarity");

endmodule

`default_nettype wire

/* File: core/ram_pkg.sv */
// constants and types shared by the block ram files
package ram_pkg;

  // array size and port widths
  localparam int TOTAL_BITS = 4096;
  localparam int MAX_DATA_WIDTH = 16;
  localparam int MAX_ADDR_WIDTH = 11;
  localparam int BASE_ADDR_WIDTH = 8;

  // array shapes; data width is 16 >> code, address width 8 + code
  typedef enum logic [1:0] {
    ram_shape_wide16 = 2'b00,
    ram_shape_wide8 = 2'b01,
    ram_shape_wide4 = 2'b10,
    ram_shape_wide2 = 2'b11
  } ram_shape_type;

  // value of the edge-sample flop after reset
  localparam logic EDGE_SAMPLE_RESET = 1'b0;
  // value of read data after reset
  localparam logic [15:0] READ_DATA_RESET = 16'h0000;

endpackage

/* File: testbench/ram_user.sv */
// user logic model that drives both ram ports through their pins
`timescale 1ns/100ps
`default_nettype none

module ram_user (
  input wire logic clock,
  output logic wr_clk,
  output logic wr_en,
  output logic wr_clk_en,
  output logic [10:0] wr_addr,
  output logic [15:0] wr_data,
  output logic [15:0] wr_mask,
  output logic rd_clk,
  output logic rd_en,
  output logic rd_clk_en,
  output logic [10:0] rd_addr
);
  initial begin
    {wr_clk, wr_en, wr_clk_en, rd_clk, rd_en, rd_clk_en} = 6'h00;
    {wr_addr, rd_addr} = 22'h0;
    {wr_data, wr_mask} = 32'h00000000;
  end

  // one pin pulse per access; qualifiers held past the falling edge
  // separate write and read ports, pseudo dual port use
  task automatic write(input logic [10:0] a, input logic [15:0] d,
                       input logic [15:0] m, input logic e, input logic c);
    @(posedge clock);
    #1;
    {wr_addr, wr_data, wr_mask, wr_en, wr_clk_en} = {a, d, m, e, c};
    wr_clk = 1'b1;
    @(posedge clock);
    #1;
    wr_clk = 1'b0;
    @(posedge clock);
    #1;
    {wr_addr, wr_data, wr_mask} = {~a, ~d, ~m};
    @(posedge clock);
  endtask

  // both edge options have answered when this returns
  task automatic read(input logic [10:0] a, input logic e, input logic c);
    @(posedge clock);
    #1;
    {rd_addr, rd_en, rd_clk_en} = {a, e, c};
    rd_clk = 1'b1;
    @(posedge clock);
    #1;
    rd_clk = 1'b0;
    @(posedge clock);
    #1;
    rd_addr = ~a;
    @(posedge clock);
    #1;
  endtask
endmodule

`default_nettype wire

/* File: testbench/tb_embedded_ram_block.sv */
// self-checking bench for the block ram in its 16-bit and 4-bit shapes
`timescale 1ns/100ps
`default_nettype none

module tb_embedded_ram_block;
  logic clock, sys_rst;
  logic wr_clk, wr_en, wr_clk_en, rd_clk, rd_en, rd_clk_en;
  logic [10:0] wr_addr, rd_addr;
  logic [15:0] wr_data, wr_mask, rd_data, rd_data_fall;
  int num_errors = 0;
  int checks_done = 0;

  ram_user user (.clock(clock), .wr_clk(wr_clk), .wr_en(wr_en),
    .wr_clk_en(wr_clk_en), .wr_addr(wr_addr), .wr_data(wr_data),
    .wr_mask(wr_mask), .rd_clk(rd_clk), .rd_en(rd_en),
    .rd_clk_en(rd_clk_en), .rd_addr(rd_addr));

  // word 0 image is all ones, word 1 holds a marker
  embedded_ram_block #(.INIT_IMAGE({4064'h0, 16'h1234, 16'hffff})) uut (
    .clock(clock), .sys_rst(sys_rst), .wr_clk(wr_clk), .wr_en(wr_en),
    .wr_clk_en(wr_clk_en), .wr_addr(wr_addr), .wr_data(wr_data),
    .wr_mask(wr_mask), .rd_clk(rd_clk), .rd_en(rd_en),
    .rd_clk_en(rd_clk_en), .rd_addr(rd_addr), .rd_data(rd_data));

  // second block on the same pins: 1024x4, both ports on falling edges
  embedded_ram_block #(.SHAPE(ram_pkg::ram_shape_wide4), .WR_FALLING(1'b1),
    .RD_FALLING(1'b1), .INIT_IMAGE({4064'h0, 16'h1234, 16'hffff}))
    uut_fall (
    .clock(clock), .sys_rst(sys_rst), .wr_clk(wr_clk), .wr_en(wr_en),
    .wr_clk_en(wr_clk_en), .wr_addr(wr_addr), .wr_data(wr_data),
    .wr_mask(wr_mask), .rd_clk(rd_clk), .rd_en(rd_en),
    .rd_clk_en(rd_clk_en), .rd_addr(rd_addr), .rd_data(rd_data_fall));

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  task automatic check(input string name, input logic [15:0] seen,
                       input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // second value is the 4-bit word of the falling-edge block
  task automatic read_check(input logic [10:0] a, input logic [15:0] exp,
                            input logic [15:0] exp_fall);
    user.read(a, 1'b1, 1'b1);
    check("rd_data", rd_data, exp);
    check("rd_data_fall", rd_data_fall, exp_fall);
  endtask

  // reads only, write controls left inactive
  task automatic test_preload();
    read_check(11'h000, 16'h0000, 16'h0000);
    read_check(11'h001, 16'h1234, 16'h000f);
  endtask

  task automatic test_mask();
    user.write(11'h0ff, 16'ha5a5, 16'h0000, 1'b1, 1'b1);
    read_check(11'h0ff, 16'ha5a5, 16'h0005);
    user.write(11'h0ff, 16'h5a5a, 16'h00ff, 1'b1, 1'b1);
    read_check(11'h0ff, 16'h5aa5, 16'h000a);
    user.write(11'h000, 16'h0f0f, 16'h0000, 1'b1, 1'b1);
    read_check(11'h000, 16'h0f0f, 16'h000f);
    read_check(11'h0ff, 16'h5aa5, 16'h000a);
  endtask

  task automatic test_enables();
    user.write(11'h002, 16'h1111, 16'h0000, 1'b0, 1'b1);
    user.write(11'h002, 16'h2222, 16'h0000, 1'b1, 1'b0);
    read_check(11'h002, 16'h0000, 16'h000f);
    read_check(11'h001, 16'h1234, 16'h000f);
    user.read(11'h0ff, 1'b0, 1'b1);
    check("rd_data", rd_data, 16'h1234);
    check("rd_data_fall", rd_data_fall, 16'h000f);
    user.read(11'h0ff, 1'b1, 1'b0);
    check("rd_data", rd_data, 16'h1234);
    check("rd_data_fall", rd_data_fall, 16'h000f);
  endtask

  // ************************************
  // main sequence
  // ************************************
  initial begin
    sys_rst = 1'b1;
    repeat (4) @(posedge clock);
    #1;
    check("rd_data", rd_data, 16'h0000);
    check("rd_data_fall", rd_data_fall, 16'h0000);
    sys_rst = 1'b0;
    test_preload();
    test_mask();
    test_enables();
    stop_test();
  end

  initial begin
    repeat (5000) @(posedge clock);
    num_errors++;
    stop_test();
  end
endmodule

`default_nettype wire
